// >>> rtl/serial_module_shell.sv
// global control shell of the dual serial module
// assumes host register port, freeze from system, port events from submodules
//
// Function
// - stop bit set gates module clock and enters low-power stop.
// - while stopped only configuration register reads are guaranteed.
// - queue RAM is not readable during low-power stop.
// - writes to RAM and registers still take effect while stopped.
// - stop bit is host-writable and set by reset.
// - freeze with halt select halts queue at next transfer boundary.
// - spare freeze bit has no effect.
// - unimplemented bits ignore writes and read as zero.
// - level and vector registers share one word, one byte each.
// - one vector register serves both submodules; levels set priorities.
// - level field selects request line of same number; zero disables.
// - vector low bit is zero for async, one for sync requests.
// - vector low bit ignores writes and reads as one.
`timescale 1ns/1ps
`include "serial_shell_defs.svh"
module serial_module_shell
	import serial_shell_pkg::*;
(
	// clock and reset
	input  wire logic                     core_clk,
	input  wire logic                     rst,
	// register port
	input  wire serial_shell_pkg::addr_t  regAddr,
	input  wire serial_shell_pkg::word_t  regWrData,
	input  wire logic                     regWr,
	input  wire logic                     regRd,
	output serial_shell_pkg::word_t       regRdData,
	// debug and submodule events
	input  wire logic                     freeze,
	input  wire logic                     transferBoundary,
	input  wire logic                     queueHaltReq,
	input  wire logic                     syncPortReq,
	input  wire logic                     asyncPortReq,
	// control outputs
	output logic                          moduleClkEn,
	output logic                          stopMode,
	output logic                          queueHalt,
	output logic      [7:1]               irqLines,
	output logic      [7:0]               ackVector,
	output logic                          irq
);
	typedef struct packed {
		logic [15:0]         cfg;
		logic [7:0]          test;
		logic [5:0]          levels;
		logic [7:1]          vector;
		logic [2:0]          stat;
		logic [2:0]          mask;
		freeze_e             frz;
		logic                rdRam;
		word_t               rdData;
		logic                haltSeen;
	} state_s;
	state_s cur_reg, cur_next;
	logic        ramWr;
	logic        ramRd;
	logic [15:0] ramRdData;
	logic        vecLow;
	logic        stopped;
	logic        inRam;
	logic [`RAM_AW-1:0] ramAddr;
	logic [2:0]  events;
	logic        haltNow;
	// implemented configuration bits: stop, freeze_halt_select, freeze_spare_bit, arbitration id
	localparam logic [15:0] CFG_MASK = 16'hE00F;
	assign stopped = cur_reg.cfg[`CFG_STOP_BIT];
	assign inRam   = regAddr >= `ADDR_RAM_BASE && regAddr < 8'(`ADDR_RAM_BASE + `RAM_WORDS);
	assign ramAddr = `RAM_AW'(regAddr - `ADDR_RAM_BASE);
	assign ramWr   = regWr && inRam;
	assign ramRd   = regRd && inRam && !stopped;
	queue_ram #(
		.WORDS (`RAM_WORDS),
		.AW    (`RAM_AW)
	) u_ram (
		.core_clk (core_clk),
		.wrEn     (ramWr),
		.rdEn     (ramRd),
		.addr     (ramAddr),
		.wrData   (regWrData),
		.rdData   (ramRdData)
	);
	irq_request_gen u_irq (
		.syncReq      (syncPortReq),
		.asyncReq     (asyncPortReq),
		.syncLevel    (cur_reg.levels[5:3]),
		.asyncLevel   (cur_reg.levels[2:0]),
		.irqLines     (irqLines),
		.vectorLowBit (vecLow)
	);
	always_comb begin
		cur_next = cur_reg;
		haltNow = 1'b0;
		cur_next.rdRam = ramRd;
		cur_next.rdData = 16'h0000;
		// freeze halt only from freeze_halt_select; freeze_spare_bit is stored and ignored
		case (cur_reg.frz)
			RUN_ST: begin
				if (freeze && cur_reg.cfg[`CFG_FREEZE_HALT_SELECT_BIT])
					cur_next.frz = WAIT_ST;
			end
			WAIT_ST: begin
				if (!freeze)
					cur_next.frz = RUN_ST;
				else if (transferBoundary)
					cur_next.frz = HALT_ST;
			end
			HALT_ST: begin
				if (!freeze || !cur_reg.cfg[`CFG_FREEZE_HALT_SELECT_BIT])
					cur_next.frz = RUN_ST;
			end
			default: cur_next.frz = RUN_ST;
		endcase
		haltNow = (cur_reg.frz == HALT_ST) || (queueHaltReq && transferBoundary);
		cur_next.haltSeen = haltNow;
		events = {haltNow && !cur_reg.haltSeen, asyncPortReq, syncPortReq};
		if (regWr) begin
			case (regAddr)
				`ADDR_CONFIG: cur_next.cfg = regWrData & CFG_MASK;
				`ADDR_TEST:   cur_next.test = regWrData[7:0];
				`ADDR_IRQ: begin
					cur_next.levels = regWrData[13:8];
					cur_next.vector = regWrData[7:1];
				end
				`ADDR_IRQ_STAT: cur_next.stat = cur_reg.stat & ~regWrData[2:0];
				`ADDR_IRQ_MASK: cur_next.mask = regWrData[2:0];
				default: ;
			endcase
		end
		// set wins over clear
		cur_next.stat = cur_next.stat | events;
		if (regRd) begin
			case (regAddr)
				`ADDR_CONFIG: cur_next.rdData = cur_reg.cfg;
				`ADDR_TEST:   cur_next.rdData = {8'h00, cur_reg.test};
				// level in high byte, vector in low byte, low bit reads one
				`ADDR_IRQ: cur_next.rdData = {2'b00, cur_reg.levels, cur_reg.vector, 1'b1};
				`ADDR_IRQ_STAT: cur_next.rdData = {13'h0000, cur_reg.stat};
				`ADDR_IRQ_MASK: cur_next.rdData = {13'h0000, cur_reg.mask};
				default: cur_next.rdData = 16'h0000;
			endcase
			// only configuration reads are meaningful while stopped
			if (stopped && regAddr != `ADDR_CONFIG)
				cur_next.rdData = 16'h0000;
		end
		if (rst) begin
			cur_next = '0;
			cur_next.cfg = `CFG_RESET;
			cur_next.vector = 7'(`VECTOR_RESET >> 1);
			cur_next.frz = RUN_ST;
		end
	end
	always_ff @(posedge core_clk) begin
		cur_reg <= cur_next;
	end
	always_comb begin
		moduleClkEn = !stopped;
		stopMode = stopped;
		queueHalt = cur_reg.frz == HALT_ST;
		ackVector = {cur_reg.vector, vecLow};
		irq = |(cur_reg.stat & cur_reg.mask);
		regRdData = cur_reg.rdRam ? ramRdData : cur_reg.rdData;
	end
endmodule : serial_module_shell

// >>> common/serial_shell_defs.svh
// offsets, field positions, reset values of the serial module global control shell
// assumes a word-addressed plain register port, 16-bit data
`ifndef SERIAL_SHELL_DEFS_SVH
`define SERIAL_SHELL_DEFS_SVH
`define ADDR_CONFIG        8'h00
`define ADDR_TEST          8'h01
`define ADDR_IRQ           8'h02
`define ADDR_IRQ_STAT      8'h03
`define ADDR_IRQ_MASK      8'h04
`define ADDR_RAM_BASE      8'h40
`define RAM_WORDS          40
`define RAM_AW             6
`define CFG_STOP_BIT       15
`define CFG_FREEZE_HALT_SELECT_BIT       14
`define CFG_FREEZE_SPARE_BIT_BIT       13
`define CFG_IARB_LSB       0
`define CFG_IARB_W         4
`define CFG_RESET          16'h8000
`define VECTOR_RESET       8'h0F
`define STAT_SYNC_BIT      0
`define STAT_ASYNC_BIT     1
`define STAT_HALT_BIT      2
`define STAT_W             3
`define TEST_W             8
`endif

// >>> common/serial_shell_pkg.sv
// types of the serial module global control shell
// assumes serial_shell_defs.svh defines the widths
`include "serial_shell_defs.svh"
package serial_shell_pkg;
	typedef logic [15:0] word_t;
	typedef logic [7:0]  addr_t;
	typedef logic [2:0]  level_t;
	typedef enum logic [1:0] {
		RUN_ST  = 2'b00,
		WAIT_ST = 2'b01,
		HALT_ST = 2'b10
	} freeze_e;
endpackage : serial_shell_pkg

// >>> rtl/queue_ram.sv
// command and data queue storage with registered read data
// assumes one access per cycle from the shell
`timescale 1ns/1ps
module queue_ram #(
	parameter int WORDS = 40,
	parameter int AW    = 6
) (
	// clock
	input  wire logic          core_clk,
	// access
	input  wire logic          wrEn,
	input  wire logic          rdEn,
	input  wire logic [AW-1:0] addr,
	input  wire logic [15:0]   wrData,
	output logic      [15:0]   rdData
);
	logic [15:0] mem [WORDS];
	always_ff @(posedge core_clk) begin
		if (wrEn)
			mem[addr] <= wrData;
		if (rdEn)
			rdData <= mem[addr];
	end
endmodule : queue_ram

// >>> rtl/irq_request_gen.sv
// maps submodule requests to internal level lines and vector low bit
// assumes request levels are sampled each cycle from the shell registers
`timescale 1ns/1ps
module irq_request_gen
	import serial_shell_pkg::*;
(
	// requests
	input  wire logic                       syncReq,
	input  wire logic                       asyncReq,
	input  wire serial_shell_pkg::level_t   syncLevel,
	input  wire serial_shell_pkg::level_t   asyncLevel,
	// result
	output logic      [7:1]                 irqLines,
	output logic                            vectorLowBit
);
	function automatic logic [7:1] decode(input level_t lvl, input logic req);
		logic [7:1] d;
		d = 7'h00;
		if (req && lvl != 3'h0)
			d[lvl] = 1'b1;
		return d;
	endfunction : decode
	always_comb begin
		irqLines = decode(syncLevel, syncReq) | decode(asyncLevel, asyncReq);
		// sync port wins whenever it requests at a nonzero level, whatever the async level
		vectorLowBit = (syncReq && syncLevel != 3'h0) ? 1'b1 : 1'b0;
	end
endmodule : irq_request_gen

// >>> bench/serial_shell_asserts.sv
// port checker for the serial module shell
// assumes it is bound onto serial_module_shell
`timescale 1ns/1ps
module serial_shell_asserts
	import serial_shell_pkg::*;
(
	// all top ports, observed only
	input wire logic core_clk, rst, regWr, regRd, freeze, transferBoundary, queueHaltReq,
	input wire logic syncPortReq, asyncPortReq, moduleClkEn, stopMode, queueHalt, irq,
	input wire serial_shell_pkg::addr_t regAddr,
	input wire serial_shell_pkg::word_t regWrData, regRdData,
	input wire logic [7:1] irqLines,
	input wire logic [7:0] ackVector
);
	default clocking @(posedge core_clk); endclocking
	default disable iff (rst);
	sequence stopRd; stopMode && regRd && regAddr != 8'h00; endsequence
	sequence runRd(a); !stopMode && regRd && regAddr == a; endsequence
	a_clk_gate: assert property (moduleClkEn == !stopMode)
		else $error("clock enable not inverse of stop");
	a_reset_stop: assert property ($fell(rst) |-> stopMode)
		else $error("not stopped after reset");
	a_idle_read: assert property (!$past(regRd) |-> regRdData == 16'h0000)
		else $error("read data outside read slot");
	a_stop_read: assert property (stopRd |=> regRdData == 16'h0000)
		else $error("stopped read returned data");
	a_cfg_read: assert property (regRd && regAddr == 8'h00 |=>
		regRdData[15] == $past(stopMode) && regRdData[12:4] == 9'h000)
		else $error("config readback wrong");
	a_vec_lsb: assert property (runRd(8'h02) |=> regRdData[0])
		else $error("vector low bit not one");
	a_halt_cause: assert property ($rose(queueHalt) |-> $past(freeze))
		else $error("halt without freeze");
	a_halt_leave: assert property ($fell(freeze) |-> ##[0:2] !queueHalt)
		else $error("halt kept after freeze");
	a_irq_idle: assert property (!syncPortReq && !asyncPortReq |-> irqLines == 7'h00)
		else $error("request line without request");
	a_ack_lsb: assert property (!syncPortReq [*2] |-> !ackVector[0])
		else $error("vector low bit set without sync request");
endmodule : serial_shell_asserts

// >>> bench/host_model.sv
// host processor model on the shell register port
// assumes tasks are entered just after a rising clock edge
`timescale 1ns/1ps
module host_model
	import serial_shell_pkg::*;
(
	input  wire logic               core_clk,
	output serial_shell_pkg::addr_t regAddr,
	output serial_shell_pkg::word_t regWrData,
	output logic                    regWr,
	output logic                    regRd
);
	initial begin
		regAddr = 8'h00;
		regWrData = 16'h0000;
		regWr = 1'b0;
		regRd = 1'b0;
	end
	task automatic wr(input addr_t a, input word_t d);
		regAddr <= a;
		regWrData <= d;
		regWr <= 1'b1;
		regRd <= 1'b0;
		@(posedge core_clk);
	endtask : wr
	task automatic rd(input addr_t a);
		regAddr <= a;
		regWrData <= ~regWrData;
		regRd <= 1'b1;
		regWr <= 1'b0;
		@(posedge core_clk);
	endtask : rd
	// the address lines toggle while idle so stale values are never trusted
	task automatic idle;
		regWr <= 1'b0;
		regRd <= 1'b0;
		regAddr <= ~regAddr;
		@(posedge core_clk);
	endtask : idle
endmodule : host_model

// >>> bench/tb.sv
// self-checking bench for the serial module shell
// assumes host_model and the shell checker are compiled first
`timescale 1ns/1ps
module tb
	import serial_shell_pkg::*;
;
	logic core_clk = 1'b0;
	logic rst, regWr, regRd, freeze, transferBoundary, queueHaltReq, syncPortReq, asyncPortReq;
	logic moduleClkEn, stopMode, queueHalt, irq, rdSeen;
	addr_t regAddr;
	word_t regWrData, regRdData, v;
	logic [7:1] irqLines;
	logic [7:0] ackVector;
	word_t exp[$];
	int failures, compares, n;
	serial_module_shell i_serial_module_shell (.*);
	host_model i_host_model (.*);
	always #20 core_clk = ~core_clk;
	always @(posedge core_clk) rdSeen <= regRd;
	always @(negedge core_clk) if (rdSeen) cmp(regRdData, exp.pop_front());
	task automatic cmp(input word_t got, input word_t want);
		compares++;
		if (got !== want) begin
			failures++;
			$display("CHECK FAILED %0t got %h want %h", $time, got, want);
		end
	endtask : cmp
	task automatic rd(input addr_t a, input word_t e);
		exp.push_back(e);
		i_host_model.rd(a);
	endtask : rd
	task automatic nap(input int k);
		repeat (k) i_host_model.idle();
		@(negedge core_clk);
	endtask : nap
	task automatic end_sim;
		$display("compares %0d failures %0d", compares, failures);
		if (failures == 0 && compares > 0) $display("STATUS OK");
		else $display("STATUS NOT OK");
		$finish;
	endtask : end_sim
	initial begin
		repeat (5000) @(posedge core_clk);
		failures++;
		end_sim();
	end
	initial begin
		{rst, freeze, transferBoundary, queueHaltReq, syncPortReq, asyncPortReq} = 6'b100000;
		void'($urandom(84));
		v = $urandom;
		repeat (16) @(posedge core_clk);
		rst <= 1'b0;
		@(negedge core_clk);
		cmp({8'h00, ackVector}, 16'h000E);
		@(posedge core_clk);
		rd(8'h00, 16'h8000);
		rd(8'h02, 16'h0000);
		i_host_model.wr(8'h40, v);
		rd(8'h40, 16'h0000);
		i_host_model.wr(8'h02, v);
		i_host_model.wr(8'h00, 16'h7FFF);
		rd(8'h00, 16'h600F);
		rd(8'h40, v);
		rd(8'h02, (v & 16'h3FFE) | 16'h0001);
		rd(8'h10, 16'h0000);
		i_host_model.wr(8'h04, 16'h0007);
		i_host_model.wr(8'h02, 16'h2B80);
		syncPortReq <= 1'b1;
		nap(2);
		cmp({9'h000, irqLines}, 16'h0010);
		cmp({8'h00, ackVector}, 16'h0081);
		cmp({15'h0000, irq}, 16'h0001);
		@(posedge core_clk);
		{syncPortReq, asyncPortReq} <= 2'b01;
		nap(2);
		cmp({9'h000, irqLines}, 16'h0004);
		cmp({8'h00, ackVector}, 16'h0080);
		@(posedge core_clk);
		asyncPortReq <= 1'b0;
		rd(8'h03, 16'h0003);
		i_host_model.wr(8'h03, 16'h0007);
		rd(8'h03, 16'h0000);
		freeze <= 1'b1;
		nap(3);
		cmp({15'h0000, queueHalt}, 16'h0000);
		@(posedge core_clk);
		transferBoundary <= 1'b1;
		@(posedge core_clk);
		transferBoundary <= 1'b0;
		for (n = 0; n < 8 && queueHalt !== 1'b1; n++) @(negedge core_clk);
		cmp({15'h0000, queueHalt}, 16'h0001);
		@(posedge core_clk);
		freeze <= 1'b0;
		nap(3);
		cmp({15'h0000, queueHalt}, 16'h0000);
		@(posedge core_clk);
		i_host_model.wr(8'h03, 16'h0007);
		queueHaltReq <= 1'b1;
		transferBoundary <= 1'b1;
		i_host_model.idle();
		transferBoundary <= 1'b0;
		nap(2);
		@(posedge core_clk);
		rd(8'h03, 16'h0004);
		i_host_model.wr(8'h04, 16'h0000);
		i_host_model.wr(8'h00, 16'hE00F);
		rd(8'h03, 16'h0000);
		nap(2);
		cmp({15'h0000, moduleClkEn}, 16'h0000);
		end_sim();
	end
endmodule : tb
bind serial_module_shell serial_shell_asserts i_serial_shell_asserts (.*);
